// file: src/ietu_pkg.sv
// package: constants and types for the interrupt and event transfer unit
package ietu_pkg;

    // ==========================================================
    // sizes
    localparam int NSRC = 16;      // request sources
    localparam int NCH = 8;        // transfer channels
    localparam int NPER = 10;      // peripheral sources 0..9
    localparam int NEXT = 3;       // fast pin sources 10..12
    localparam int NXB = 3;        // extension bus nodes 13..15
    localparam int EXT_BASE = 10;
    localparam int XB_BASE = 13;
    localparam int NEV = 3;        // interrupt status events

    // ==========================================================
    // vector table
    localparam logic [7:0] TRAP_BASE = 8'h10;

    // ==========================================================
    // register map, word index on the address port
    localparam logic [7:0] A_SRC = 8'h00;   // 16 source controls
    localparam logic [7:0] A_CCTL = 8'h10;  // 8 channel controls
    localparam logic [7:0] A_SPTR = 8'h18;  // 8 source pointers
    localparam logic [7:0] A_DPTR = 8'h20;  // 8 destination pointers
    localparam logic [7:0] A_STAT = 8'h30;  // sticky events, w1c
    localparam logic [7:0] A_MASK = 8'h31;  // event mask
    localparam logic [7:0] A_STATE = 8'h32; // arbiter state

    // ==========================================================
    // reset values and writable bits
    localparam logic [15:0] SRC_RST = 16'h0000;
    localparam logic [15:0] CCTL_RST = 16'h0000;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [NEV-1:0] MASK_RST = 3'h0;
    localparam logic [15:0] SRC_WMASK = 16'h3fcf;
    localparam logic [15:0] CCTL_WMASK = 16'h07ff;

    // ==========================================================
    // status event bits
    localparam int EV_DONE = 0;    // channel count reached zero
    localparam int EV_INT = 1;     // source interrupt offered
    localparam int EV_TRAP = 2;    // software trap offered

    // ==========================================================
    // response time at the 10 ns clock
    localparam int CLK_NS = 10;
    localparam int LAT_MIN_NS = 250;
    localparam int LAT_MAX_NS = 600;
    localparam int LAT_MIN_CYC = (LAT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int LAT_MAX_CYC = LAT_MAX_NS / CLK_NS;

    // ==========================================================
    // types
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_OFFER = 1'b1
    } ietu_state_t;

    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [1:0] edge_sel;     // bit0 rising, bit1 falling
        logic [2:0] chan;         // transfer channel
        logic xfer;               // 1: event transfer service
        logic req;                // request flag
        logic en;                 // enable flag
        logic [1:0] rsv_lo;
        logic [3:0] lvl;          // priority level
    } ietu_src_t;

    typedef struct packed {
        logic [4:0] rsv;
        logic cont;               // continuous mode
        logic inc_dst;            // 1: step destination pointer
        logic word;               // 1: word move, 0: byte move
        logic [7:0] count;        // transfers left
    } ietu_chan_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ietu_bus_t;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic word;
    } ietu_xfer_t;

endpackage

// file: src/ietu_top.sv
// interrupt controller with peripheral event transfer channels
`timescale 1ns/1ns
module ietu_top
(
    input wire logic ref_clk,                 // 100 MHz clock
    input wire logic nrst,                    // sync reset, low
    input wire logic clk_en,                  // freezes all state
    input wire ietu_pkg::ietu_bus_t bus,      // register request
    output logic [15:0] rdata_q,              // read data
    input wire logic [ietu_pkg::NPER-1:0] per_req, // peripheral pulses
    input wire logic [ietu_pkg::NEXT-1:0] ext_pin, // async fast pins
    input wire logic [ietu_pkg::NXB-1:0] xb_req,   // bus node pulses
    input wire logic trap_valid,              // trap instruction
    input wire logic [7:0] trap_num,          // trap number
    input wire logic [3:0] cpu_level,         // running priority
    input wire logic int_ack,                 // cpu took vector
    output logic int_req_q,                   // interrupt offered
    output logic [15:0] int_vec_q,            // vector address
    output logic [3:0] int_lvl_q,             // offered level
    output logic xfer_valid_q,                // one stolen cycle
    output ietu_pkg::ietu_xfer_t xfer_q,      // move to perform
    output logic irq_q                        // event interrupt
);
    import ietu_pkg::*;

    localparam int LAT_HI = LAT_MAX_CYC;

    // checks sample on the rising edge and rest during reset
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // ==========================================================
    // helpers
    function automatic logic [15:0] vec_addr(input logic [7:0] t);
        vec_addr = {6'h00, t, 2'b00};
    endfunction

    function automatic logic [15:0] step(input logic w);
        step = w ? 16'h0002 : 16'h0001;
    endfunction

    // ==========================================================
    // state
    ietu_src_t src_q [NSRC];
    ietu_chan_t cc_q [NCH];
    logic [15:0] sp_q [NCH];
    logic [15:0] dp_q [NCH];
    logic [NEV-1:0] stat_q;
    logic [NEV-1:0] mask_q;
    ietu_state_t state_q;
    logic trap_pend_q;
    logic [7:0] trap_num_q;
    logic svc_src_q;
    logic [3:0] svc_idx_q;
    logic [NEXT-1:0] ext_s1_q;
    logic [NEXT-1:0] ext_s2_q;
    logic [NEXT-1:0] ext_p_q;

    // ==========================================================
    // fast pin edges after the synchroniser
    wire [NEXT-1:0] ext_rise = ext_s2_q & ~ext_p_q;
    wire [NEXT-1:0] ext_fall = ~ext_s2_q & ext_p_q;
    logic [NSRC-1:0] hw_set;

    // request sources onto flags
    always_comb
    begin
        hw_set = '0;
        hw_set[NPER-1:0] = per_req;
        for (int i = 0; i < NEXT; i++)
        begin
            hw_set[EXT_BASE + i] =
                (ext_rise[i] & src_q[EXT_BASE + i].edge_sel[0]) |
                (ext_fall[i] & src_q[EXT_BASE + i].edge_sel[1]);
        end
        for (int i = 0; i < NXB; i++)
        begin
            hw_set[XB_BASE + i] = xb_req[i];
        end
    end

    // ==========================================================
    // arbitration: highest enabled level, lowest index on a tie
    logic win_any;
    logic [3:0] win_lvl;
    logic [3:0] win_idx;

    always_comb
    begin
        win_any = 1'b0;
        win_lvl = 4'h0;
        win_idx = 4'h0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (src_q[i].req && src_q[i].en &&
                (!win_any || src_q[i].lvl > win_lvl))
            begin
                win_any = 1'b1;
                win_lvl = src_q[i].lvl;
                win_idx = 4'(i);
            end
        end
    end

    // service decisions
    wire win_ok = win_any && (win_lvl > cpu_level);
    wire [2:0] win_ch = src_q[win_idx].chan;
    ietu_chan_t sel;
    assign sel = cc_q[win_ch];
    wire xfer_go = src_q[win_idx].xfer &&
        (sel.cont || sel.count != 8'h00);
    wire idle = clk_en && (state_q == ST_IDLE);
    wire take_trap = idle && trap_pend_q;
    // cpu gets a cycle back between two steals
    wire take_xfer = idle && !trap_pend_q && win_ok && xfer_go &&
        !xfer_valid_q;
    wire take_int = idle && !trap_pend_q && win_ok && !xfer_go;
    wire int_done = clk_en && (state_q == ST_OFFER) && int_ack;
    wire last = !sel.cont && (sel.count == 8'h01);
    wire [7:0] win_trap = TRAP_BASE + {4'h0, win_idx};

    // ==========================================================
    // register decode
    wire wr_src = bus.wr && (bus.addr[7:4] == A_SRC[7:4]);
    wire wr_cc = bus.wr && (bus.addr[7:3] == A_CCTL[7:3]);
    wire wr_sp = bus.wr && (bus.addr[7:3] == A_SPTR[7:3]);
    wire wr_dp = bus.wr && (bus.addr[7:3] == A_DPTR[7:3]);
    wire wr_stat = bus.wr && (bus.addr == A_STAT);
    wire wr_mask = bus.wr && (bus.addr == A_MASK);
    wire [3:0] a_src = bus.addr[3:0];
    wire [2:0] a_ch = bus.addr[2:0];
    wire [NEV-1:0] ev = {take_trap, take_int, take_xfer && last};
    logic [15:0] rd_val;

    // read selection, unmapped reads as zero
    always_comb
    begin
        rd_val = 16'h0000;
        if (bus.addr[7:4] == A_SRC[7:4])
            rd_val = src_q[a_src];
        else if (bus.addr[7:3] == A_CCTL[7:3])
            rd_val = cc_q[a_ch];
        else if (bus.addr[7:3] == A_SPTR[7:3])
            rd_val = sp_q[a_ch];
        else if (bus.addr[7:3] == A_DPTR[7:3])
            rd_val = dp_q[a_ch];
        else if (bus.addr == A_STAT)
            rd_val = {13'h0000, stat_q};
        else if (bus.addr == A_MASK)
            rd_val = {13'h0000, mask_q};
        else if (bus.addr == A_STATE)
            rd_val = {svc_idx_q, int_lvl_q, 6'h00, trap_pend_q,
                      state_q == ST_OFFER};
    end

    // ==========================================================
    // fast pin synchroniser and edge history
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            ext_s1_q <= '0;
            ext_s2_q <= '0;
            ext_p_q <= '0;
        end
        else if (clk_en)
        begin
            ext_s1_q <= ext_pin;
            ext_s2_q <= ext_s1_q;
            ext_p_q <= ext_s2_q;
        end
    end

    // source control registers, hardware set wins over clear
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            if (!nrst)
                src_q[i] <= SRC_RST;
            else if (clk_en)
            begin
                if (wr_src && a_src == 4'(i))
                    src_q[i] <= bus.wdata & SRC_WMASK;
                if ((take_xfer && !last && win_idx == 4'(i)) ||
                    (int_done && svc_src_q && svc_idx_q == 4'(i)))
                    src_q[i].req <= 1'b0;
                if (hw_set[i])
                    src_q[i].req <= 1'b1;
            end
        end
    end

    // transfer channels: pointer step and count
    always_ff @(posedge ref_clk)
    begin
        for (int c = 0; c < NCH; c++)
        begin
            if (!nrst)
            begin
                cc_q[c] <= CCTL_RST;
                sp_q[c] <= PTR_RST;
                dp_q[c] <= PTR_RST;
            end
            else if (clk_en)
            begin
                if (wr_cc && a_ch == 3'(c))
                    cc_q[c] <= bus.wdata & CCTL_WMASK;
                if (wr_sp && a_ch == 3'(c))
                    sp_q[c] <= bus.wdata;
                if (wr_dp && a_ch == 3'(c))
                    dp_q[c] <= bus.wdata;
                if (take_xfer && win_ch == 3'(c))
                begin
                    if (sel.inc_dst)
                        dp_q[c] <= dp_q[c] + step(sel.word);
                    else
                        sp_q[c] <= sp_q[c] + step(sel.word);
                    if (!sel.cont)
                        cc_q[c].count <= sel.count - 8'h01;
                end
            end
        end
    end

    // trap capture, a new trap while one waits is ignored unless the waiting one is taken in that cycle
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            trap_pend_q <= 1'b0;
            trap_num_q <= 8'h00;
        end
        else if (clk_en)
        begin
            if (trap_valid && (!trap_pend_q || take_trap))
            begin
                trap_pend_q <= 1'b1;
                trap_num_q <= trap_num;
            end
            else if (take_trap)
                trap_pend_q <= 1'b0;
        end
    end

    // offer to the cpu and one-cycle transfer strobe
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            int_req_q <= 1'b0;
            int_vec_q <= 16'h0000;
            int_lvl_q <= 4'h0;
            svc_src_q <= 1'b0;
            svc_idx_q <= 4'h0;
            xfer_valid_q <= 1'b0;
            xfer_q <= '0;
        end
        else if (clk_en)
        begin
            xfer_valid_q <= take_xfer;
            if (take_xfer)
                xfer_q <= '{src: sp_q[win_ch], dst: dp_q[win_ch],
                            word: sel.word};
            case (state_q)
                ST_IDLE:
                begin
                    if (take_trap)
                    begin
                        state_q <= ST_OFFER;
                        int_req_q <= 1'b1;
                        int_vec_q <= vec_addr(trap_num_q);
                        int_lvl_q <= cpu_level;
                        svc_src_q <= 1'b0;
                    end
                    else if (take_int)
                    begin
                        state_q <= ST_OFFER;
                        int_req_q <= 1'b1;
                        int_vec_q <= vec_addr(win_trap);
                        int_lvl_q <= win_lvl;
                        svc_src_q <= 1'b1;
                        svc_idx_q <= win_idx;
                    end
                end
                ST_OFFER:
                begin
                    if (int_ack)
                    begin
                        state_q <= ST_IDLE;
                        int_req_q <= 1'b0;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    int_req_q <= 1'b0;
                end
            endcase
        end
    end

    // status, mask, interrupt line and read data
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            stat_q <= '0;
            mask_q <= MASK_RST;
            irq_q <= 1'b0;
            rdata_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            stat_q <= (stat_q & ~(wr_stat ? bus.wdata[NEV-1:0] : '0))
                | ev;
            if (wr_mask)
                mask_q <= bus.wdata[NEV-1:0];
            irq_q <= |(stat_q & mask_q);
            rdata_q <= bus.rd ? rd_val : 16'h0000;
        end
    end

    // ==========================================================
    // checks
    chk_one_steal: assert property (
        xfer_valid_q && clk_en |=> !xfer_valid_q)
        else $error("transfer strobe longer than one cycle");

    chk_count_dec: assert property (
        take_xfer |=> cc_q[$past(win_ch)].count ==
            ($past(sel.cont) ? $past(sel.count)
                             : $past(sel.count) - 8'h01))
        else $error("channel count not stepped correctly");

    chk_ptr_step: assert property (
        take_xfer && !sel.inc_dst |=> sp_q[$past(win_ch)] ==
            $past(sp_q[win_ch]) + step($past(sel.word)))
        else $error("source pointer not stepped");

    chk_zero_int: assert property (
        take_xfer && last |=> src_q[$past(win_idx)].req ##0
            (!clk_en || state_q != ST_IDLE || trap_pend_q ||
             !win_ok || !xfer_go))
        else $error("empty channel does not fall back to interrupt");

    chk_level_above: assert property (
        take_int |=> int_req_q && int_lvl_q > $past(cpu_level))
        else $error("offered level not above cpu level");

    chk_src_vector: assert property (
        take_int |=> int_vec_q ==
            {6'h00, TRAP_BASE + {4'h0, $past(win_idx)}, 2'b00})
        else $error("source vector wrong");

    chk_trap_vector: assert property (
        take_trap |=> int_req_q && int_vec_q == vec_addr($past(trap_num_q)))
        else $error("trap vector wrong");

    chk_offer_hold: assert property (
        int_req_q && !int_ack |=> int_req_q)
        else $error("offer dropped before acknowledge");

    chk_pin_rise: assert property (
        clk_en && ext_rise[0] && src_q[EXT_BASE].edge_sel[0]
        |=> src_q[EXT_BASE].req)
        else $error("rising pin edge lost");

    chk_resp_time: assert property (
        take_int |-> ##[1:LAT_HI] int_req_q)
        else $error("response later than allowed");

endmodule

// file: testbench/ietu_cpu_model.sv
// cpu core stand-in that takes offered vectors after a set delay
`timescale 1ns/1ns
module ietu_cpu_model
(
    input wire logic ref_clk,        // system clock
    input wire logic nrst,           // sync reset, low
    input wire logic int_req,        // offer from the block
    input wire logic [15:0] int_vec, // offered vector
    input wire logic [3:0] ack_dly,  // cycles before taking
    output logic int_ack,            // vector taken
    output logic [15:0] last_vec     // last vector taken
);
    logic [3:0] wait_q;

    // ==========================================================
    // take an offer after ack_dly cycles, one-cycle acknowledge
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            int_ack <= 1'b0;
            wait_q <= 4'h0;
            last_vec <= 16'h0000;
        end
        else if (int_ack)
        begin
            int_ack <= 1'b0;
            wait_q <= 4'h0;
        end
        else if (int_req)
        begin
            if (wait_q == ack_dly)
            begin
                int_ack <= 1'b1;     // suspend and branch
                last_vec <= int_vec; // entry of the source
            end
            else
            begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// file: testbench/ietu_top_test.sv
// self-checking bench for the interrupt and event transfer unit
`timescale 1ns/1ns
module ietu_top_test;
    import ietu_pkg::*;
    logic ref_clk, nrst, trap_valid, int_ack, int_req_q, xfer_valid_q, irq_q;
    logic clk_en;
    logic [15:0] rdata_q, int_vec_q, last_vec;
    logic [NPER-1:0] per_req;
    logic [NEXT-1:0] ext_pin;
    logic [NXB-1:0] xb_req;
    logic [7:0] trap_num;
    logic [3:0] cpu_level, int_lvl_q, ack_dly;
    ietu_bus_t bus;
    ietu_xfer_t xfer_q;
    int errors, n_checks;

    // ==========================================================
    // design and cpu stand-in
    ietu_top u_ietu_top (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
        .bus(bus), .rdata_q(rdata_q), .per_req(per_req), .ext_pin(ext_pin),
        .xb_req(xb_req), .trap_valid(trap_valid), .trap_num(trap_num),
        .cpu_level(cpu_level), .int_ack(int_ack), .int_req_q(int_req_q),
        .int_vec_q(int_vec_q), .int_lvl_q(int_lvl_q),
        .xfer_valid_q(xfer_valid_q), .xfer_q(xfer_q), .irq_q(irq_q));
    ietu_cpu_model u_ietu_cpu_model (.ref_clk(ref_clk), .nrst(nrst),
        .int_req(int_req_q), .int_vec(int_vec_q), .ack_dly(ack_dly),
        .int_ack(int_ack), .last_vec(last_vec));

    // ==========================================================
    // shared tasks
    task test_done;
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd_chk(input logic [7:0] a, input logic [15:0] exp);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 check(33'(rdata_q), 33'(exp));
        @(posedge ref_clk);
    endtask
    task pulse(input logic [NPER-1:0] m);
        per_req <= m;
        @(posedge ref_clk);
        per_req <= '0;
    endtask
    task chk_irq(input logic exp);
        #1 check(33'(irq_q), 33'(exp));
        @(posedge ref_clk);
    endtask
    // offer must come within the response bound, then be taken
    task wait_offer(input logic [15:0] vec, input logic [3:0] lvl);
        int n;
        n = 0;
        #1;
        while (int_req_q !== 1'b1 && n < LAT_MAX_CYC)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(33'(int_req_q), 33'h1);
        check(33'(int_vec_q), 33'(vec));
        check(33'(int_lvl_q), 33'(lvl));
        while (int_req_q === 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(33'(last_vec), 33'(vec));
        @(posedge ref_clk);
    endtask
    task wait_none(input int k);
        repeat (k)
        begin
            @(posedge ref_clk);
            #1 check(33'(int_req_q), 33'h0);
        end
        @(posedge ref_clk);
    endtask
    // one stolen cycle, no offer beside it
    task wait_xfer(input logic [32:0] exp);
        int n;
        n = 0;
        #1;
        while (xfer_valid_q !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(33'(xfer_valid_q), 33'h1);
        check(xfer_q, exp);
        check(33'(int_req_q), 33'h0);
        @(posedge ref_clk);
        #1 check(33'(xfer_valid_q), 33'h0);
        @(posedge ref_clk);
    endtask
    task pin_step(input int i, input logic [1:0] sel, input logic lv,
                  input logic hit);
        wr(8'(i), {2'b00, sel, 12'h046});
        ext_pin[i-EXT_BASE] <= lv;
        @(posedge ref_clk);
        if (hit)
            wait_offer(16'h0040 + 16'(4 * i), 4'h6);
        else
            wait_none(12);
    endtask

    // ==========================================================
    // scenarios
    task t_regs;
        rd_chk(A_SRC, SRC_RST);
        rd_chk(A_CCTL + 8'h07, CCTL_RST);
        rd_chk(A_DPTR, PTR_RST);
        rd_chk(A_MASK, 16'h0000);
        rd_chk(8'h3f, 16'h0000);
        cpu_level <= 4'hf;
        wr(A_SRC + 8'h09, 16'hffff);
        rd_chk(A_SRC + 8'h09, SRC_WMASK);
        wr(A_CCTL, 16'hffff);
        rd_chk(A_CCTL, CCTL_WMASK);
        wr(A_SRC + 8'h09, 16'h0000);
        wr(A_CCTL, 16'h0000);
        cpu_level <= 4'h0;
    endtask
    task t_standard;
        wr(A_SRC + 8'h03, 16'h0045);
        pulse(10'h008);
        wait_offer(16'h004c, 4'h5);
        rd_chk(A_SRC + 8'h03, 16'h0045);
    endtask
    task t_priority;
        ack_dly <= 4'h6;
        wr(A_SRC + 8'h01, 16'h0043);
        wr(A_SRC + 8'h02, 16'h004f);
        cpu_level <= 4'h3;
        pulse(10'h006);
        wait_offer(16'h0048, 4'hf);
        wait_none(8);
        cpu_level <= 4'h2;
        @(posedge ref_clk);
        wait_offer(16'h0044, 4'h3);
        cpu_level <= 4'h0;
        ack_dly <= 4'h2;
    endtask
    task t_transfer;
        wr(A_STAT, 16'h0007);
        wr(A_CCTL + 8'h02, 16'h0102);
        wr(A_SPTR + 8'h02, 16'h1000);
        wr(A_DPTR + 8'h02, 16'h2000);
        wr(A_SRC + 8'h04, 16'h0544);
        pulse(10'h010);
        wait_xfer({16'h1000, 16'h2000, 1'b1});
        rd_chk(A_SPTR + 8'h02, 16'h1002);
        rd_chk(A_CCTL + 8'h02, 16'h0101);
        pulse(10'h010);
        wait_xfer({16'h1002, 16'h2000, 1'b1});
        wait_offer(16'h0050, 4'h4);
        rd_chk(A_CCTL + 8'h02, 16'h0100);
        rd_chk(A_STAT, 16'h0003);
        wr(A_CCTL + 8'h07, 16'h0600);
        wr(A_SPTR + 8'h07, 16'h0100);
        wr(A_DPTR + 8'h07, 16'h3000);
        wr(A_SRC + 8'h05, 16'h0f45);
        for (int k = 0; k < 2; k++)
        begin
            pulse(10'h020);
            wait_xfer({16'h0100, 16'h3000 + 16'(k), 1'b0});
        end
        rd_chk(A_DPTR + 8'h07, 16'h3002);
        rd_chk(A_CCTL + 8'h07, 16'h0600);
    endtask
    task t_pins;
        pin_step(10, 2'b01, 1'b1, 1'b1);
        pin_step(10, 2'b01, 1'b0, 1'b0);
        pin_step(10, 2'b10, 1'b1, 1'b0);
        pin_step(10, 2'b10, 1'b0, 1'b1);
        pin_step(11, 2'b11, 1'b1, 1'b1);
        pin_step(11, 2'b11, 1'b0, 1'b1);
    endtask
    task t_traps_nodes;
        cpu_level <= 4'h2;
        trap_num <= 8'h25;
        trap_valid <= 1'b1;
        @(posedge ref_clk);
        trap_valid <= 1'b0;
        wait_offer(16'h0094, 4'h2);
        cpu_level <= 4'h0;
        wr(A_SRC + 8'h0d, 16'h00c7);
        wait_offer(16'h0074, 4'h7);
        for (int j = 0; j < NXB; j++)
        begin
            wr(A_SRC + 8'(XB_BASE + j), 16'h0047);
            xb_req <= 3'(1 << j);
            @(posedge ref_clk);
            xb_req <= '0;
            wait_offer(16'h0074 + 16'(4 * j), 4'h7);
        end
    endtask
    task t_irq;
        wr(A_STAT, 16'h0007);
        wr(A_MASK, 16'h0002);
        rd_chk(A_STAT, 16'h0000);
        trap_num <= 8'h11;
        trap_valid <= 1'b1;
        @(posedge ref_clk);
        trap_valid <= 1'b0;
        wait_offer(16'h0044, 4'h0);
        chk_irq(1'b0);
        pulse(10'h008);
        wait_offer(16'h004c, 4'h5);
        chk_irq(1'b1);
        rd_chk(A_STAT, 16'h0006);
        wr(A_STAT, 16'h0002);
        chk_irq(1'b0);
        rd_chk(A_STAT, 16'h0004);
    endtask
    // a request seen while frozen is never taken
    task t_freeze;
        clk_en <= 1'b0;
        pulse(10'h008);
        wait_none(4);
        clk_en <= 1'b1;
        wait_none(4);
        rd_chk(A_SRC + 8'h03, 16'h0045);
    endtask

    // ==========================================================
    // clock, sequence and watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        errors = 0;
        n_checks = 0;
        bus = '0;
        per_req = '0;
        ext_pin = '0;
        xb_req = '0;
        trap_valid = 1'b0;
        trap_num = 8'h00;
        cpu_level = 4'h0;
        ack_dly = 4'h2;
        clk_en = 1'b1;
        nrst = 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_regs;
        t_standard;
        t_priority;
        t_transfer;
        t_pins;
        t_traps_nodes;
        t_irq;
        t_freeze;
        test_done;
    end
    initial
    begin
        #200000;
        errors++;
        test_done;
    end
endmodule
